/* rtl/pef_defs.svh */
// Summary of operation
// - top bit 1 shows unmasked key/adapter pending
// - top bit 0 shows interrupt drive level
// - battery below threshold sets bit 2
// - thermal level one crossing sets bit 1
// - thermal level two crossing sets bit 0
// - key rising sets bit 3; read clears
// - key held one second sets bit 1
// - warning one hard-off step early, bit 0
// - top bit 7 shows unmasked battery/thermal pending
`ifndef PEF_DEFS_SVH
`define PEF_DEFS_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define PEF_IDX_TOP 6'h00
`define PEF_IDX_BT_FLAGS 6'h01
`define PEF_IDX_PK_FLAGS 6'h02
`define PEF_IDX_BT_MASK 6'h10
`define PEF_IDX_PK_MASK 6'h11
`define PEF_IDX_CONFIG 6'h12

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PEF_TOP_BT_PEND 7
`define PEF_TOP_PK_PEND 1
`define PEF_TOP_IRQ 0
`define PEF_BT_LOW 2
`define PEF_BT_TJ1 1
`define PEF_BT_TJ2 0
`define PEF_PK_AC_RISE 5
`define PEF_PK_AC_FALL 4
`define PEF_PK_KEY_RISE 3
`define PEF_PK_KEY_FALL 2
`define PEF_PK_LONG 1
`define PEF_PK_WARN 0
`define PEF_BT_FLAG_W 3
`define PEF_PK_FLAG_W 6
`define PEF_HOFF_W 3

// ------------------------------------------------------------
// pin slots in the synchroniser vector
// ------------------------------------------------------------
`define PEF_PIN_BAT 0
`define PEF_PIN_TJ1 1
`define PEF_PIN_TJ2 2
`define PEF_PIN_KEY 3
`define PEF_PIN_AC 4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PEF_RST_BT_FLAGS 3'h0
`define PEF_RST_PK_FLAGS 6'h00
`define PEF_RST_MASK 8'h00
`define PEF_RST_HOFF 3'h0
`define PEF_RST_DATA 32'h0000_0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PEF_CLK_KHZ 200000
`define PEF_LONG_HOLD_MS 1000
`define PEF_HOFF_STEP_MS 1000
`define PEF_HOFF_MIN_WARN 3'h2

`endif

/* rtl/pef_pkg.sv */
package pef_pkg;
   typedef logic [7:0] pef_byte_t;
   typedef logic [5:0] pef_idx_t;
   typedef logic [31:0] pef_cnt_t;
endpackage

/* rtl/pef_lvl_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pef_lvl_if #(parameter int W = 1);
   logic [W-1:0] clean;
   modport src (output clean);
   modport dst (input clean);
endinterface
`default_nettype wire

/* rtl/pef_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pef_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] raw,
   pef_lvl_if.src lvl
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] clean_ff;

   // ------------------------------------------------------------
   // three stages, change taken once stages two and three agree
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               clean_ff[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
               clean_ff[i] <= s3_ff[i];
            end
         end
      end
   endgenerate

   assign lvl.clean = clean_ff;
endmodule
`default_nettype wire

/* rtl/pef_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pef_defs.svh"
module pef_top
   import pef_pkg::*;
#(
   parameter int unsigned LONG_HOLD_CYCLES = `PEF_LONG_HOLD_MS * `PEF_CLK_KHZ,
   parameter int unsigned HOFF_STEP_CYCLES = `PEF_HOFF_STEP_MS * `PEF_CLK_KHZ
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic battery_below_threshold,
   input wire logic thermal_over_level_one,
   input wire logic thermal_over_level_two,
   input wire logic power_key_input,
   input wire logic adapter_present_input,
   output logic irq_out
);

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   localparam int NPIN = 5;

   logic [NPIN-1:0] pins_raw;

   assign pins_raw[`PEF_PIN_BAT] = battery_below_threshold;
   assign pins_raw[`PEF_PIN_TJ1] = thermal_over_level_one;
   assign pins_raw[`PEF_PIN_TJ2] = thermal_over_level_two;
   assign pins_raw[`PEF_PIN_KEY] = power_key_input;
   assign pins_raw[`PEF_PIN_AC] = adapter_present_input;

   pef_lvl_if #(.W(NPIN)) pins_if ();

   pef_sync #(.W(NPIN)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .raw(pins_raw),
      .lvl(pins_if.src)
   );

   logic [NPIN-1:0] cur;
   logic [NPIN-1:0] prev_ff;
   logic [NPIN-1:0] rise;
   logic [NPIN-1:0] fall;

   assign cur = pins_if.clean;
   assign rise = cur & ~prev_ff;
   assign fall = ~cur & prev_ff;

   // prev starts low, so a pin already high at reset gives one rising edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= cur;
      end
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic setup;
   logic access;
   logic aligned;
   pef_idx_t idx;
   logic mapped;
   // answer registers, read here by the decode and the clear logic
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_ff;
   assign aligned = (paddr[1:0] == 2'b00);
   assign idx = paddr[7:2];

   // unaligned or unknown index is refused
   always_comb begin
      mapped = 1'b0;
      if (aligned) begin
         unique case (idx)
            `PEF_IDX_TOP, `PEF_IDX_BT_FLAGS, `PEF_IDX_PK_FLAGS,
            `PEF_IDX_BT_MASK, `PEF_IDX_PK_MASK, `PEF_IDX_CONFIG: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   pef_byte_t bt_mask_ff;
   pef_byte_t pk_mask_ff;
   logic [`PEF_HOFF_W-1:0] hoff_set_ff;
   logic wr_hit;

   assign wr_hit = access & pwrite & mapped;

   // flag registers and top summary are read only, writes drop
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bt_mask_ff <= `PEF_RST_MASK;
         pk_mask_ff <= `PEF_RST_MASK;
         hoff_set_ff <= `PEF_RST_HOFF;
      end else if (wr_hit) begin
         if (idx == `PEF_IDX_BT_MASK) begin
            bt_mask_ff <= pwdata[7:0];
         end
         if (idx == `PEF_IDX_PK_MASK) begin
            pk_mask_ff <= pwdata[7:0];
         end
         if (idx == `PEF_IDX_CONFIG) begin
            hoff_set_ff <= pwdata[`PEF_HOFF_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // power key hold timer
   // ------------------------------------------------------------
   pef_cnt_t hold_cnt_ff;
   pef_cnt_t warn_cycles;
   logic key_lvl;
   logic long_hit;
   logic warn_hit;

   assign key_lvl = cur[`PEF_PIN_KEY];

   // saturates, so a very long press never wraps into a second hit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hold_cnt_ff <= '0;
      end else if (!key_lvl) begin
         hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != '1) begin
         hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
      end
   end

   // warning sits one hard-off step ahead of the programmed time
   assign warn_cycles = 32'(hoff_set_ff - 3'h1) * 32'(HOFF_STEP_CYCLES);
   assign long_hit = key_lvl && (hold_cnt_ff == 32'(LONG_HOLD_CYCLES - 1));
   // settings below two give no warning, there is no earlier step
   assign warn_hit = key_lvl && (hoff_set_ff >= `PEF_HOFF_MIN_WARN) &&
                     (hold_cnt_ff == warn_cycles - 32'h0000_0001);

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------
   logic [`PEF_BT_FLAG_W-1:0] bt_flags_ff;
   logic [`PEF_PK_FLAG_W-1:0] pk_flags_ff;
   logic [`PEF_BT_FLAG_W-1:0] bt_set;
   logic [`PEF_PK_FLAG_W-1:0] pk_set;
   logic [`PEF_BT_FLAG_W-1:0] bt_clr;
   logic [`PEF_PK_FLAG_W-1:0] pk_clr;
   logic rd_done;
   logic rd_bt;
   logic rd_pk;

   // edges come after the synchroniser agrees, about four cycles late
   always_comb begin
      bt_set = '0;
      bt_set[`PEF_BT_LOW] = rise[`PEF_PIN_BAT];
      bt_set[`PEF_BT_TJ1] = rise[`PEF_PIN_TJ1];
      bt_set[`PEF_BT_TJ2] = rise[`PEF_PIN_TJ2];
      pk_set = '0;
      pk_set[`PEF_PK_AC_RISE] = rise[`PEF_PIN_AC];
      pk_set[`PEF_PK_AC_FALL] = fall[`PEF_PIN_AC];
      pk_set[`PEF_PK_KEY_RISE] = rise[`PEF_PIN_KEY];
      pk_set[`PEF_PK_KEY_FALL] = fall[`PEF_PIN_KEY];
      pk_set[`PEF_PK_LONG] = long_hit;
      pk_set[`PEF_PK_WARN] = warn_hit;
   end

   // only bits shown to the reader clear, so a later event is never lost
   assign rd_done = access & ~pwrite;
   assign rd_bt = rd_done && aligned && (idx == `PEF_IDX_BT_FLAGS);
   assign rd_pk = rd_done && aligned && (idx == `PEF_IDX_PK_FLAGS);
   assign bt_clr = rd_bt ? prdata_ff[`PEF_BT_FLAG_W-1:0] : '0;
   assign pk_clr = rd_pk ? prdata_ff[`PEF_PK_FLAG_W-1:0] : '0;

   // set wins over clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bt_flags_ff <= `PEF_RST_BT_FLAGS;
      end else begin
         bt_flags_ff <= (bt_flags_ff & ~bt_clr) | bt_set;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pk_flags_ff <= `PEF_RST_PK_FLAGS;
      end else begin
         pk_flags_ff <= (pk_flags_ff & ~pk_clr) | pk_set;
      end
   end

   // ------------------------------------------------------------
   // group summaries and interrupt drive
   // ------------------------------------------------------------
   logic bt_pend;
   logic pk_pend;
   logic irq_ff;

   // mask bit high blocks the flag
   assign bt_pend = |(bt_flags_ff & ~bt_mask_ff[`PEF_BT_FLAG_W-1:0]);
   assign pk_pend = |(pk_flags_ff & ~pk_mask_ff[`PEF_PK_FLAG_W-1:0]);

   // registered so the pin never glitches while flags settle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= bt_pend | pk_pend;
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // pending bits are live, bit 0 is the registered drive
   pef_byte_t rd_byte;

   always_comb begin
      rd_byte = '0;
      if (aligned) begin
         unique case (idx)
            `PEF_IDX_TOP: begin
               rd_byte[`PEF_TOP_BT_PEND] = bt_pend;
               rd_byte[`PEF_TOP_PK_PEND] = pk_pend;
               rd_byte[`PEF_TOP_IRQ] = irq_ff;
            end
            `PEF_IDX_BT_FLAGS: begin
               // upper bits read zero, host ignores them anyway
               rd_byte[`PEF_BT_FLAG_W-1:0] = bt_flags_ff;
            end
            `PEF_IDX_PK_FLAGS: begin
               rd_byte[`PEF_PK_FLAG_W-1:0] = pk_flags_ff;
            end
            `PEF_IDX_BT_MASK: begin
               rd_byte = bt_mask_ff;
            end
            `PEF_IDX_PK_MASK: begin
               rd_byte = pk_mask_ff;
            end
            `PEF_IDX_CONFIG: begin
               rd_byte[`PEF_HOFF_W-1:0] = hoff_set_ff;
            end
            default: begin
               rd_byte = '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // apb answer, data captured in setup, one access cycle
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata_ff <= `PEF_RST_DATA;
      end else if (setup) begin
         prdata_ff <= pwrite ? `PEF_RST_DATA : {24'h00_0000, rd_byte};
      end
   end

   // refusal stands one cycle, together with pready
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         pslverr_ff <= ~mapped;
      end else begin
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq_out = irq_ff;

endmodule
`default_nettype wire

/* sim/pef_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pef_host (
   input wire logic clock,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ----------------------------------------
   // apb master, one transfer per call
   // ----------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // called just after a rising edge; waits as long as the slave needs,
   // only the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show inverted leftovers, not stale values
      paddr <= ~a;
      pwdata <= ~d;
      // one idle edge, so the next call never re-drives psel in this step
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

/* sim/pef_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module pef_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq_out
);
   // ----------------------------------------
   // bus and summary properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   rdy_next_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   rdy_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   rdy_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   err_unal_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("unaligned access not refused");
   err_ok_a: assert property (psel && !penable &&
      paddr inside {8'h00, 8'h04, 8'h08, 8'h40, 8'h44, 8'h48} |=> !pslverr)
      else $error("mapped access refused");
   err_rdy_a: assert property (pslverr |-> pready)
      else $error("pslverr outside answer");
   rsv_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
      else $error("read data on write");
   irq_bit_a: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=>
      prdata[0] == $past(irq_out)) else $error("summary bit0 differs from irq");
endmodule
bind pef_top pef_checker u_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq_out(irq_out));
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pef_pkg::*;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq_out;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic bat, tj1, tj2, key, ac;
   int errors, n_tests;
   logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h44, 8'h48};
   // short hold counts keep the run brief
   pef_top #(.LONG_HOLD_CYCLES(50), .HOFF_STEP_CYCLES(20)) dut (.clock(clock),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .battery_below_threshold(bat), .thermal_over_level_one(tj1),
      .thermal_over_level_two(tj2), .power_key_input(key),
      .adapter_present_input(ac), .irq_out(irq_out));
   pef_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, logic eexp);
      logic [31:0] r;
      logic e;
      host.xfer(1'b0, a, 32'h0000_0000, r, e);
      chk($sformatf("reg %h", a), r, {24'h00_0000, exp});
      chk("pslverr", {31'h0000_0000, e}, {31'h0000_0000, eexp});
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      logic [31:0] r;
      logic e;
      host.xfer(1'b1, a, {24'h00_0000, d}, r, e);
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
   endtask
   task end_sim;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      end_sim;
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      {bat, tj1, tj2, key, ac} = 5'h00;
      cyc(10);
      rst_n <= 1'b1;
      foreach (ra[i]) rd(ra[i], 8'h00, 1'b0);
      rd(8'h0C, 8'h00, 1'b1);
      rd(8'h01, 8'h00, 1'b1);
      wr(8'h44, 8'h5A);
      rd(8'h44, 8'h5A, 1'b0);
      wr(8'h04, 8'h07);
      rd(8'h04, 8'h00, 1'b0);
      tj1 <= 1'b1;
      cyc(10);
      chk("irq_out", {31'h0000_0000, irq_out}, 32'h0000_0001);
      rd(8'h00, 8'h81, 1'b0);
      rd(8'h04, 8'h02, 1'b0);
      rd(8'h04, 8'h00, 1'b0);
      rd(8'h00, 8'h00, 1'b0);
      chk("irq_out", {31'h0000_0000, irq_out}, 32'h0000_0000);
      bat <= 1'b1;
      tj2 <= 1'b1;
      cyc(10);
      rd(8'h04, 8'h05, 1'b0);
      wr(8'h44, 8'h3F);
      ac <= 1'b1;
      cyc(10);
      rd(8'h00, 8'h00, 1'b0);
      wr(8'h44, 8'h00);
      cyc(2);
      rd(8'h00, 8'h03, 1'b0);
      rd(8'h08, 8'h20, 1'b0);
      wr(8'h48, 8'h03);
      rd(8'h48, 8'h03, 1'b0);
      key <= 1'b1;
      cyc(10);
      rd(8'h08, 8'h08, 1'b0);
      cyc(34);
      rd(8'h08, 8'h01, 1'b0);
      cyc(10);
      rd(8'h08, 8'h02, 1'b0);
      key <= 1'b0;
      ac <= 1'b0;
      cyc(10);
      rd(8'h08, 8'h14, 1'b0);
      rd(8'h08, 8'h00, 1'b0);
      end_sim;
   end
endmodule
`default_nettype wire
